// ---- inc/dioe_regs.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef DIOE_REGS_SVH
`define DIOE_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define DIOE_OFS_SPEED_RPM      8'h00
`define DIOE_OFS_PULSE_COUNT    8'h01
`define DIOE_OFS_COUNT_CLEAR    8'h02
`define DIOE_OFS_FAULT_CHECKS   8'h03
`define DIOE_OFS_RESOLUTION     8'h04
`define DIOE_OFS_OUTPUT_STATE   8'h05
`define DIOE_OFS_IR_COMMAND     8'h06
`define DIOE_OFS_IR_HANDSET     8'h07
`define DIOE_OFS_INPUT_CONFIG   8'h08
`define DIOE_OFS_DRIVE_STATUS   8'h09
`define DIOE_OFS_RAMP_CONFIG    8'h0A
`define DIOE_OFS_SPEED_LEVEL0   8'h10

// ****************************************************************
// reset values
// ****************************************************************
`define DIOE_RST_FAULT_CHECKS   2'h3
`define DIOE_RST_RESOLUTION     16'h0400
`define DIOE_RST_COUNT_CLEAR    1'h0
`define DIOE_RST_IR_HANDSET     1'h0
`define DIOE_RST_POLARITY       1'h0

// ****************************************************************
// field positions of the input configuration register
// ****************************************************************
`define DIOE_FLD_POLARITY       0
`define DIOE_FLD_EP_MODE        1
`define DIOE_FLD_FLY_MODE_LO    2
`define DIOE_FLD_FLY_MODE_HI    3

// ****************************************************************
// numeric limits and timing
// ****************************************************************
`define DIOE_COUNT_MAX          16'd9999
`define DIOE_RPM_MAX            32'sd9999
`define DIOE_CLK_MHZ            125
`define DIOE_WINDOW_MS          6
`define DIOE_WINDOW_CYCLES      (`DIOE_WINDOW_MS * 1000 * `DIOE_CLK_MHZ)

`endif

// ---- inc/dioe_pkg.sv ----
// types shared by the drive input/output and encoder logic
package dioe_pkg;

    typedef enum logic [1:0] {
        DIOE_LOCK_ARMED,
        DIOE_LOCK_WAIT_LOW,
        DIOE_LOCK_LIVE
    } dioe_lock_type;

    typedef logic [15:0] dioe_word_type;

endpackage

// ---- hw/dioe_sync.sv ----
// two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none

module dioe_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // dioe_sync

`default_nettype wire

// ---- hw/dioe_top.sv ----
// drive digital input decoding, encoder counter and status registers
`timescale 1ns/1ps
`default_nettype none

`include "dioe_regs.svh"

module dioe_top
    import dioe_pkg::*;
#(
    parameter int WINDOW_CYCLES = `DIOE_WINDOW_CYCLES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // field input pins, raw level
    input  wire logic [2:0]  speed_sel_pin,
    input  wire logic        ramp2_pin,
    input  wire logic        alarm_ok_pin,
    input  wire logic        fault_ok_pin,
    input  wire logic        fault_reset_pin,
    input  wire logic        fly_inhibit_pin,
    input  wire logic        prog_lock_pin,
    input  wire logic        ep_accel_pin,
    input  wire logic        ep_decel_pin,
    input  wire logic        stop_pulse_pin,
    input  wire logic        stop_inact_pin,
    input  wire logic        run_lock_pin,
    input  wire logic        enc_a_pin,
    input  wire logic        enc_b_pin,
    // from the drive controller
    input  wire logic [3:0]  relay_output_line,
    input  wire logic [15:0] ir_command_in,
    input  wire logic        at_min_speed,
    input  wire logic        enc_wiring_err,
    input  wire logic        enc_signal_err,
    // to the drive controller
    output logic      [15:0] speed_reference,
    output logic             use_alternate_ramp,
    output logic             external_alarm,
    output logic             external_fault,
    output logic             pwm_disable,
    output logic             fault_active,
    output logic             flying_start_en,
    output logic             drive_enable,
    output logic             run_cmd,
    output logic             encoder_wiring_fault,
    output logic             encoder_signal_fault,
    output logic             infrared_handset_type
);

    // ****************************************************************
    // input synchronisation and polarity
    // ****************************************************************
    localparam int NPIN = 16;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_s;
    logic [13:0]     act;
    logic            input_polarity_setting_q;

    assign pin_raw = {enc_b_pin, enc_a_pin, run_lock_pin, stop_inact_pin,
                      stop_pulse_pin, ep_decel_pin, ep_accel_pin,
                      prog_lock_pin, fly_inhibit_pin, fault_reset_pin,
                      fault_ok_pin, alarm_ok_pin, ramp2_pin, speed_sel_pin};

    dioe_sync #(.WIDTH(NPIN)) u_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .async_in (pin_raw),
        .sync_out (pin_s)
    );

    // sinking mode: low pin is active; sourcing mode: high pin is active
    genvar gi;
    generate
        for (gi = 0; gi < 14; gi++) begin : g_pol
            assign act[gi] = pin_s[gi] ^ ~input_polarity_setting_q;
        end
    endgenerate

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    logic [15:0] speed_level_q [8];
    logic [15:0] ramp_cfg_q;
    logic [1:0]  fault_checks_q;
    logic [15:0] resolution_q;
    logic        ir_handset_q;
    logic        ep_mode_q;
    logic [1:0]  fly_mode_q;
    logic        clear_req_q;
    logic        wr_ok;

    assign wr_ok = reg_wr && !act[8];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_checks_q           <= `DIOE_RST_FAULT_CHECKS;
            resolution_q             <= `DIOE_RST_RESOLUTION;
            ir_handset_q             <= `DIOE_RST_IR_HANDSET;
            input_polarity_setting_q <= `DIOE_RST_POLARITY;
            ep_mode_q                <= 1'b0;
            fly_mode_q               <= 2'h0;
            ramp_cfg_q               <= 16'h0000;
        end else if (wr_ok) begin
            if (reg_addr == `DIOE_OFS_FAULT_CHECKS) begin
                fault_checks_q <= reg_wdata[1:0];
            end else if (reg_addr == `DIOE_OFS_RESOLUTION) begin
                // out-of-range resolution is ignored to keep speed sane
                if (reg_wdata >= 16'd32 && reg_wdata <= `DIOE_COUNT_MAX) begin
                    resolution_q <= reg_wdata;
                end
            end else if (reg_addr == `DIOE_OFS_IR_HANDSET) begin
                ir_handset_q <= reg_wdata[0];
            end else if (reg_addr == `DIOE_OFS_INPUT_CONFIG) begin
                input_polarity_setting_q <= reg_wdata[`DIOE_FLD_POLARITY];
                ep_mode_q  <= reg_wdata[`DIOE_FLD_EP_MODE];
                fly_mode_q <= reg_wdata[`DIOE_FLD_FLY_MODE_HI:
                                        `DIOE_FLD_FLY_MODE_LO];
            end else if (reg_addr == `DIOE_OFS_RAMP_CONFIG) begin
                ramp_cfg_q <= reg_wdata;
            end
        end
    end

    generate
        for (gi = 0; gi < 8; gi++) begin : g_lvl
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    speed_level_q[gi] <= 16'h0000;
                end else if (wr_ok && reg_addr ==
                             `DIOE_OFS_SPEED_LEVEL0 + 8'(gi)) begin
                    speed_level_q[gi] <= reg_wdata;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // digital input functions
    // ****************************************************************
    logic [13:0] act_prev_q;
    logic        fault_q;
    logic        enable_q;
    dioe_lock_type lock_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            speed_reference    <= 16'h0000;
            use_alternate_ramp <= 1'b0;
            external_alarm     <= 1'b0;
            // cleared synchroniser reads as all active: no false edge
            act_prev_q         <= '1;
        end else begin
            speed_reference    <= speed_level_q[act[2:0]];
            use_alternate_ramp <= act[3];
            external_alarm     <= !act[4];
            act_prev_q         <= act;
        end
    end

    // fault latches at once; reset needs cause gone and reset input active
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_q <= 1'b0;
        end else if (!act[5]) begin
            fault_q <= 1'b1;
        end else if (act[6] && fault_q) begin
            fault_q <= 1'b0;
        end
    end

    assign external_fault = fault_q;
    assign fault_active   = fault_q;
    assign pwm_disable    = fault_q || !act[5];
    assign flying_start_en = (fly_mode_q == 2'h1 || fly_mode_q == 2'h2)
                             && !act[7];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            enable_q <= 1'b0;
        end else if (act[11] && !act_prev_q[11]) begin
            enable_q <= 1'b0;
        end else if (!act[12] && act_prev_q[12]) begin
            enable_q <= 1'b0;
        end else if (ep_mode_q && act[10] && !act_prev_q[10]
                     && at_min_speed) begin
            enable_q <= 1'b0;
        end else if (ep_mode_q && act[9] && !act_prev_q[9] && !fault_q) begin
            enable_q <= 1'b1;
        end
    end

    assign drive_enable = enable_q && !fault_q;

    // run input held at power-up stays dead until released and re-pressed
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_q <= DIOE_LOCK_ARMED;
        end else begin
            case (lock_q)
                DIOE_LOCK_ARMED: begin
                    lock_q <= act[13] ? DIOE_LOCK_WAIT_LOW : DIOE_LOCK_LIVE;
                end
                DIOE_LOCK_WAIT_LOW: begin
                    if (!act[13]) begin
                        lock_q <= DIOE_LOCK_LIVE;
                    end
                end
                default: begin
                    lock_q <= DIOE_LOCK_LIVE;
                end
            endcase
        end
    end

    // run line has its own pin, gated by the power-up lock
    assign run_cmd = (lock_q == DIOE_LOCK_LIVE) && act[13];

    // ****************************************************************
    // quadrature decoder and pulse counter
    // ****************************************************************
    logic [1:0]  ab_q;
    logic [1:0]  ab;
    logic        step;
    logic        dir_cw;
    logic        dir_cw_q;
    logic [15:0] count_q;

    assign ab     = {pin_s[14], pin_s[15]};
    assign step   = (ab != ab_q) && (ab[0] ^ ab[1] ^ ab_q[0] ^ ab_q[1]);
    assign dir_cw = ab_q[0] ^ ab[1];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ab_q     <= 2'h0;
            dir_cw_q <= 1'b1;
        end else begin
            ab_q <= ab;
            if (step) begin
                dir_cw_q <= dir_cw;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= 16'h0000;
        end else if (clear_req_q) begin
            count_q <= dir_cw_q ? 16'h0000 : `DIOE_COUNT_MAX;
        end else if (step && dir_cw) begin
            count_q <= (count_q >= `DIOE_COUNT_MAX) ? 16'h0000
                                                    : count_q + 16'd1;
        end else if (step) begin
            count_q <= (count_q == 16'h0000) ? `DIOE_COUNT_MAX
                                             : count_q - 16'd1;
        end
    end

    // write sets, completed load clears next cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clear_req_q <= `DIOE_RST_COUNT_CLEAR;
        end else if (wr_ok && reg_addr == `DIOE_OFS_COUNT_CLEAR
                     && reg_wdata[0]) begin
            clear_req_q <= 1'b1;
        end else begin
            clear_req_q <= 1'b0;
        end
    end

    // ****************************************************************
    // speed measurement over a fixed window
    // ****************************************************************
    logic [31:0]        win_cnt_q;
    logic signed [31:0] edge_acc_q;
    logic signed [15:0] rpm_q;
    logic signed [47:0] rpm_full;
    logic signed [31:0] rpm_calc;
    logic               win_end;

    assign win_end = (win_cnt_q == 32'(WINDOW_CYCLES - 1));
    // four edges per pulse, 10000 windows of 6ms per minute
    assign rpm_full = (48'(edge_acc_q) * 48'sd10000)
                      / (48'sd4 * $signed({32'h0, resolution_q}));
    assign rpm_calc = 32'(rpm_full);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            win_cnt_q  <= 32'h0000_0000;
            edge_acc_q <= 32'sh0000_0000;
            rpm_q      <= 16'sh0000;
        end else if (win_end) begin
            win_cnt_q  <= 32'h0000_0000;
            // a step on the closing edge belongs to the next window
            edge_acc_q <= !step ? 32'sh0000_0000
                                : (dir_cw ? 32'sd1 : -32'sd1);
            if (rpm_calc > `DIOE_RPM_MAX) begin
                rpm_q <= 16'sd9999;
            end else if (rpm_calc < -`DIOE_RPM_MAX) begin
                rpm_q <= -16'sd9999;
            end else begin
                rpm_q <= 16'(rpm_calc);
            end
        end else begin
            win_cnt_q <= win_cnt_q + 32'h0000_0001;
            if (step) begin
                edge_acc_q <= dir_cw ? edge_acc_q + 32'sd1
                                     : edge_acc_q - 32'sd1;
            end
        end
    end

    assign encoder_wiring_fault = fault_checks_q[0] && enc_wiring_err;
    assign encoder_signal_fault = fault_checks_q[1] && enc_signal_err;
    assign infrared_handset_type = ir_handset_q;

    // ****************************************************************
    // register read port
    // ****************************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 16'h0000;
        end else if (!reg_rd) begin
            reg_rdata <= 16'h0000;
        end else if (reg_addr == `DIOE_OFS_SPEED_RPM) begin
            reg_rdata <= rpm_q;
        end else if (reg_addr == `DIOE_OFS_PULSE_COUNT) begin
            reg_rdata <= count_q;
        end else if (reg_addr == `DIOE_OFS_COUNT_CLEAR) begin
            reg_rdata <= {15'h0000, clear_req_q};
        end else if (reg_addr == `DIOE_OFS_FAULT_CHECKS) begin
            reg_rdata <= {14'h0000, fault_checks_q};
        end else if (reg_addr == `DIOE_OFS_RESOLUTION) begin
            reg_rdata <= resolution_q;
        end else if (reg_addr == `DIOE_OFS_OUTPUT_STATE) begin
            reg_rdata <= {12'h000, relay_output_line};
        end else if (reg_addr == `DIOE_OFS_IR_COMMAND) begin
            reg_rdata <= ir_command_in;
        end else if (reg_addr == `DIOE_OFS_IR_HANDSET) begin
            reg_rdata <= {15'h0000, ir_handset_q};
        end else if (reg_addr == `DIOE_OFS_INPUT_CONFIG) begin
            reg_rdata <= {12'h000, fly_mode_q, ep_mode_q,
                          input_polarity_setting_q};
        end else if (reg_addr == `DIOE_OFS_DRIVE_STATUS) begin
            reg_rdata <= {10'h000, run_cmd, enable_q, external_alarm,
                          fault_q, dir_cw_q, act[8]};
        end else if (reg_addr == `DIOE_OFS_RAMP_CONFIG) begin
            reg_rdata <= ramp_cfg_q;
        end else if (reg_addr[7:3] == 5'h02) begin
            reg_rdata <= speed_level_q[reg_addr[2:0]];
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_CLR_SELF: assert property (@(posedge clk) disable iff (!arst_n)
        clear_req_q |=> !clear_req_q)
        else $error("clear request did not drop");
    AST_CLR_LOAD: assert property (@(posedge clk) disable iff (!arst_n)
        clear_req_q |=> (count_q == 16'h0000 || count_q == `DIOE_COUNT_MAX))
        else $error("clear did not load a limit");
    AST_CNT_RANGE: assert property (@(posedge clk) disable iff (!arst_n)
        count_q <= `DIOE_COUNT_MAX)
        else $error("pulse count out of range");
    AST_FAULT_PWM: assert property (@(posedge clk) disable iff (!arst_n)
        !act[5] |-> pwm_disable ##1 fault_q)
        else $error("fault input did not cut pwm");
    AST_FAULT_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
        (fault_q && !act[6]) |=> fault_q)
        else $error("fault cleared without reset input");
    AST_LOCK_WR: assert property (@(posedge clk) disable iff (!arst_n)
        (reg_wr && act[8]) |=> $stable(resolution_q)
            && $stable(fault_checks_q) && $stable(ir_handset_q))
        else $error("write passed while locked");
    AST_RPM_RANGE: assert property (@(posedge clk) disable iff (!arst_n)
        rpm_q <= 16'sd9999 && rpm_q >= -16'sd9999)
        else $error("rpm out of range");
    AST_ALARM: assert property (@(posedge clk) disable iff (!arst_n)
        !act[4] |=> external_alarm)
        else $error("alarm not raised");
    AST_FLY: assert property (@(posedge clk) disable iff (!arst_n)
        act[7] |-> !flying_start_en)
        else $error("flying start not inhibited");
    AST_RUNLOCK: assert property (@(posedge clk) disable iff (!arst_n)
        (lock_q == DIOE_LOCK_WAIT_LOW) |-> !run_cmd)
        else $error("run passed through power-up lock");

endmodule // dioe_top

`default_nettype wire

// ---- verif/dioe_enc_model.sv ----
// behavioural quadrature encoder standing at the far side of the block
`timescale 1ns/1ps
`default_nettype none

module dioe_enc_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // motion request from the bench
    input  wire logic step,
    input  wire logic cw,
    // encoder channels
    output logic      enc_a_pin,
    output logic      enc_b_pin
);
    logic [1:0] ph_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ph_q <= 2'h0;
        end else if (step) begin
            ph_q <= cw ? ph_q + 2'h1 : ph_q - 2'h1;
        end
    end

    // gray order: channel a leads b when turning clockwise
    assign enc_a_pin = ph_q[1] ^ ph_q[0];
    assign enc_b_pin = ph_q[1];
endmodule // dioe_enc_model

`default_nettype wire

// ---- verif/tb.sv ----
// self-checking testbench for the drive input and encoder block
`timescale 1ns/1ps
`default_nettype none

`include "dioe_regs.svh"

module tb;
    logic        clk, arst_n, reg_wr, reg_rd, step, cw;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, ir_command_in, speed_reference;
    logic [3:0]  relay_output_line;
    logic [2:0]  speed_sel_pin;
    logic        ramp2_pin, alarm_ok_pin, fault_ok_pin, fault_reset_pin;
    logic        fly_inhibit_pin, prog_lock_pin, ep_accel_pin, ep_decel_pin;
    logic        stop_pulse_pin, stop_inact_pin, run_lock_pin, enc_a_pin;
    logic        enc_b_pin, at_min_speed, enc_wiring_err, enc_signal_err;
    logic        use_alternate_ramp, external_alarm, external_fault;
    logic        pwm_disable, fault_active, flying_start_en, drive_enable;
    logic        run_cmd, encoder_wiring_fault, encoder_signal_fault;
    logic        infrared_handset_type;
    int          n_fail, total_checks;

    // short window keeps the speed measurement inside a brief run
    dioe_top #(.WINDOW_CYCLES(100)) i_dioe_top (.clk, .arst_n, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .speed_sel_pin, .ramp2_pin,
        .alarm_ok_pin, .fault_ok_pin, .fault_reset_pin, .fly_inhibit_pin,
        .prog_lock_pin, .ep_accel_pin, .ep_decel_pin, .stop_pulse_pin,
        .stop_inact_pin, .run_lock_pin, .enc_a_pin, .enc_b_pin,
        .relay_output_line, .ir_command_in, .at_min_speed, .enc_wiring_err,
        .enc_signal_err, .speed_reference, .use_alternate_ramp,
        .external_alarm, .external_fault, .pwm_disable, .fault_active,
        .flying_start_en, .drive_enable, .run_cmd, .encoder_wiring_fault,
        .encoder_signal_fault, .infrared_handset_type);
    dioe_enc_model i_dioe_enc_model (.clk, .arst_n, .step, .cw, .enc_a_pin,
        .enc_b_pin);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ****************************************************************
    // access tasks
    // ****************************************************************
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(nm, e, reg_rdata);
        @(posedge clk);
    endtask
    // sinking mode: a pin pulled low is an active input
    task automatic pulse(input int k);
        case (k)
            0: ep_accel_pin <= 1'b0;
            1: ep_decel_pin <= 1'b0;
            2: stop_pulse_pin <= 1'b0;
            default: fault_reset_pin <= 1'b0;
        endcase
        wt(6);
        {ep_accel_pin, ep_decel_pin, stop_pulse_pin, fault_reset_pin} <= 4'hF;
        wt(6);
    endtask
    task automatic steps(input logic d, input int n);
        repeat (n) begin
            @(posedge clk);
            step <= 1'b1;
            cw <= d;
            @(posedge clk);
            step <= 1'b0;
            wt(3);
        end
    endtask
    task automatic end_sim;
        if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #200us;
        n_fail++;
        end_sim();
    end

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        {reg_wr, reg_rd, step, cw, at_min_speed, stop_inact_pin} = '0;
        {reg_addr, reg_wdata, relay_output_line, ir_command_in} = '0;
        {ramp2_pin, fault_reset_pin, fly_inhibit_pin, prog_lock_pin} = 4'hF;
        // run line already active at power-up
        {ep_accel_pin, ep_decel_pin, stop_pulse_pin, run_lock_pin} = 4'hE;
        {alarm_ok_pin, fault_ok_pin, speed_sel_pin} = 5'h07;
        {enc_wiring_err, enc_signal_err} = 2'h3;
        arst_n = 1'b0;
        wt(8);
        arst_n <= 1'b1;
        rdc("clear", `DIOE_OFS_COUNT_CLEAR, 16'h0000);
        rdc("checks", `DIOE_OFS_FAULT_CHECKS, 16'h0003);
        rdc("res", `DIOE_OFS_RESOLUTION, 16'h0400);
        rdc("handset", `DIOE_OFS_IR_HANDSET, 16'h0000);
        wr(`DIOE_OFS_IR_HANDSET, 16'h0001);
        rdc("handset", `DIOE_OFS_IR_HANDSET, 16'h0001);
        chk("handset_pin", 16'h0001, {15'h0, infrared_handset_type});
        wr(`DIOE_OFS_RESOLUTION, 16'd31);
        rdc("res", `DIOE_OFS_RESOLUTION, 16'h0400);
        wr(`DIOE_OFS_RESOLUTION, 16'd32);
        rdc("res", `DIOE_OFS_RESOLUTION, 16'h0020);
        rdc("unmapped", 8'h20, 16'h0000);
        relay_output_line <= 4'hA;
        ir_command_in <= 16'hFFFF;
        rdc("outputs", `DIOE_OFS_OUTPUT_STATE, 16'h000A);
        rdc("ir", `DIOE_OFS_IR_COMMAND, 16'hFFFF);
        for (int m = 0; m < 4; m++) begin
            wr(`DIOE_OFS_FAULT_CHECKS, 16'(m));
            wt(1);
            chk("wiring", 16'(m & 1), {15'h0, encoder_wiring_fault});
            chk("loss", 16'(m >> 1), {15'h0, encoder_signal_fault});
        end
        for (int i = 0; i < 8; i++) wr(8'(`DIOE_OFS_SPEED_LEVEL0 + i), 16'(i));
        for (int i = 0; i < 8; i++) begin
            speed_sel_pin <= ~3'(i);
            wt(6);
            chk("speed_ref", 16'(i), speed_reference);
        end
        ramp2_pin <= 1'b0;
        alarm_ok_pin <= 1'b1;
        wt(6);
        chk("alt_ramp", 16'h0001, {15'h0, use_alternate_ramp});
        chk("alarm", 16'h0001, {15'h0, external_alarm});
        chk("pwm_off", 16'h0000, {15'h0, pwm_disable});
        {ramp2_pin, alarm_ok_pin} <= 2'b10;
        wt(6);
        chk("alt_ramp", 16'h0000, {15'h0, use_alternate_ramp});
        chk("alarm", 16'h0000, {15'h0, external_alarm});
        for (int m = 0; m < 4; m++) begin
            wr(`DIOE_OFS_INPUT_CONFIG, 16'(m << 2));
            wt(6);
            chk("fly", 16'(m == 1 || m == 2), {15'h0, flying_start_en});
            fly_inhibit_pin <= 1'b0;
            wt(6);
            chk("fly", 16'h0000, {15'h0, flying_start_en});
            fly_inhibit_pin <= 1'b1;
        end
        wr(`DIOE_OFS_INPUT_CONFIG, 16'h0002);
        pulse(0);
        pulse(1);
        chk("enable", 16'h0001, {15'h0, drive_enable});
        at_min_speed <= 1'b1;
        pulse(1);
        chk("enable", 16'h0000, {15'h0, drive_enable});
        pulse(0);
        pulse(2);
        chk("enable", 16'h0000, {15'h0, drive_enable});
        pulse(0);
        chk("enable", 16'h0001, {15'h0, drive_enable});
        stop_inact_pin <= 1'b1;
        wt(6);
        chk("enable", 16'h0000, {15'h0, drive_enable});
        chk("run", 16'h0000, {15'h0, run_cmd});
        run_lock_pin <= 1'b1;
        wt(6);
        run_lock_pin <= 1'b0;
        wt(6);
        chk("run", 16'h0001, {15'h0, run_cmd});
        fault_ok_pin <= 1'b1;
        wt(6);
        chk("ext_fault", 16'h0001, {15'h0, external_fault});
        chk("pwm_off", 16'h0001, {15'h0, pwm_disable});
        pulse(3);
        chk("fault", 16'h0001, {15'h0, fault_active});
        fault_ok_pin <= 1'b0;
        pulse(3);
        chk("fault", 16'h0000, {15'h0, fault_active});
        prog_lock_pin <= 1'b0;
        wt(6);
        wr(`DIOE_OFS_IR_HANDSET, 16'h0000);
        rdc("locked", `DIOE_OFS_IR_HANDSET, 16'h0001);
        prog_lock_pin <= 1'b1;
        wt(6);
        wr(`DIOE_OFS_IR_HANDSET, 16'h0000);
        rdc("unlocked", `DIOE_OFS_IR_HANDSET, 16'h0000);
        steps(1'b1, 48);
        rdc("rpm", `DIOE_OFS_SPEED_RPM, 16'h061A);
        rdc("count", `DIOE_OFS_PULSE_COUNT, 16'h0030);
        wr(`DIOE_OFS_COUNT_CLEAR, 16'h0001);
        wt(2);
        rdc("count", `DIOE_OFS_PULSE_COUNT, 16'h0000);
        rdc("clear", `DIOE_OFS_COUNT_CLEAR, 16'h0000);
        steps(1'b0, 8);
        rdc("count", `DIOE_OFS_PULSE_COUNT, 16'h2708);
        wr(`DIOE_OFS_COUNT_CLEAR, 16'h0001);
        wt(2);
        rdc("count", `DIOE_OFS_PULSE_COUNT, `DIOE_COUNT_MAX);
        wr(`DIOE_OFS_INPUT_CONFIG, 16'h0001);
        ramp2_pin <= 1'b1;
        wt(6);
        chk("alt_ramp", 16'h0001, {15'h0, use_alternate_ramp});
        end_sim();
    end
endmodule // tb

`default_nettype wire
